// *** verilog/irq_pend_pkg.sv ***
// Constants and carrier types of the IRQ pending/index stage.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package irq_pend_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [31:0] ADDR_IRQ_PENDING  = 32'h4a00_0010;  // W1C
  localparam logic [31:0] ADDR_IRQ_INDEX    = 32'h4a00_0014;  // RO
  localparam logic [31:0] ADDR_SUB_PENDING  = 32'h4a00_0018;  // W1C
  localparam logic [31:0] ADDR_EVT_STATUS   = 32'h4a00_0020;  // RO sticky
  localparam logic [31:0] ADDR_EVT_CLEAR    = 32'h4a00_0024;  // WO
  localparam logic [31:0] ADDR_EVT_ENABLE   = 32'h4a00_0028;  // RW
  localparam logic [31:0] ADDR_WORD_MASK    = 32'hffff_fffc;  // Drop byte bits

  // ------------------------------------------------------------------
  // Widths, reset values and field layout
  // ------------------------------------------------------------------
  localparam int          NUM_SOURCES       = 32;
  localparam int          INDEX_W           = 5;
  localparam int          SUB_W             = 11;
  localparam int          EVT_W             = 2;
  localparam logic [31:0] PENDING_RESET     = 32'h0000_0000;
  localparam logic [4:0]  INDEX_RESET       = 5'h00;
  localparam logic [10:0] SUB_RESET         = 11'h000;
  localparam logic [1:0]  EVT_RESET         = 2'h0;
  // Positions 24 and 6 are reserved and never set
  localparam logic [31:0] SOURCE_VALID      = 32'hfeff_ffbf;
  localparam int          EVT_IRQ_TAKEN     = 0;  // Pending loaded
  localparam int          EVT_SUB_SET       = 1;  // Any sub request

  // ------------------------------------------------------------------
  // Bus responses
  // ------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  // One UART channel's three sub-requests, msb first
  typedef struct packed {
    logic error_request;
    logic transmit_request;
    logic receive_request;
  } uart_req_t;

  // Sub-source layout, bit 10 down to bit 0
  typedef struct packed {
    logic      adc_request;
    logic      touch_request;
    uart_req_t uart2;
    uart_req_t uart1;
    uart_req_t uart0;
  } sub_req_t;

  // Per-source request context from the surrounding controller
  typedef struct packed {
    logic [31:0] source_pending;  // Latched source requests
    logic [31:0] mask;            // 1 = service masked
    logic [31:0] fiq_mode;        // 1 = fast interrupt mode
    logic [31:0] grant;           // Arbiter winner, one-hot
  } src_ctx_t;

endpackage

// *** verilog/lowest_set_pick.sv ***
// Picks the lowest set bit of a vector as one-hot plus its index.
// Pure combinational; caller registers the result.
`timescale 1ns/10ps
module lowest_set_pick #(
  parameter int W  = 32,
  parameter int IW = 5
) (
  input  wire logic [W-1:0]  vec,
  output logic      [W-1:0]  onehot,
  output logic      [IW-1:0] index,
  output logic               any
);

  // ------------------------------------------------------------------
  // Scan from the top so the lowest bit is written last and wins
  // ------------------------------------------------------------------
  always_comb begin
    onehot = '0;
    index  = '0;
    any    = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (vec[i]) begin
        onehot = '0;
        onehot[i] = 1'b1;
        index  = IW'(i);
        any    = 1'b1;
      end
    end
  end

endmodule // lowest_set_pick

// *** verilog/irq_pending_offset_logic.sv ***
// IRQ pending, source index and sub-source pending stage with an
// AXI4-Lite register slave and an event interrupt output.
// Assumes source pending, mask, mode and arbiter live outside on aclk.
//
// Function
// - At most one pending bit, it drives IRQ
// - Pending write clears bits written one
// - Fast-mode requests never set pending bits
// - Index register returns pending bit position
// - Index clears once both pending bits clear
// - Fast-mode requests leave index unchanged
// - Pending resets zero, bits 24, 6 zero
// - Eleven sub-request flags, upper bits read zero
// - Sub pending write clears bits written one
// - Masked sources never reach irq pending
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module irq_pending_offset_logic (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0]          awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  // AXI4-Lite write data
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // AXI4-Lite write response
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read address
  input  wire logic [31:0]          araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  // AXI4-Lite read data
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Source context from the surrounding controller
  input  wire irq_pend_pkg::src_ctx_t src_ctx,
  // Sub-source request pulses
  input  wire irq_pend_pkg::sub_req_t sub_request,
  // Toward the core and the system
  output logic                      cpu_irq,
  output logic                      evt_irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0] pending_r;      // One-hot irq pending flags
  logic [31:0] pending_nxt;
  logic [4:0]  index_r;        // Source index of pending bit
  logic [4:0]  index_nxt;
  logic [10:0] sub_r;          // Sub-source pending flags
  logic [10:0] sub_nxt;
  logic [1:0]  evt_status_r;   // Sticky events
  logic [1:0]  evt_status_nxt;
  logic [1:0]  evt_enable_r;   // Event enables
  logic [1:0]  evt_enable_nxt;
  logic        cpu_irq_r;
  logic        evt_irq_r;

  // Bus slave state
  logic        aw_held_r;      // Write address captured
  logic        w_held_r;       // Write data captured
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // ------------------------------------------------------------------
  // Candidate selection
  // ------------------------------------------------------------------
  logic [31:0] candidates;     // Eligible IRQ-mode requests
  logic [31:0] pick_onehot;
  logic [4:0]  pick_index;
  logic        pick_any;
  logic        load;           // Pending register takes a winner

  assign candidates = src_ctx.grant & src_ctx.source_pending & ~src_ctx.mask
                    & ~src_ctx.fiq_mode & irq_pend_pkg::SOURCE_VALID;

  // Guards the one-hot property even if the grant is not one-hot
  lowest_set_pick #(
    .W  (irq_pend_pkg::NUM_SOURCES),
    .IW (irq_pend_pkg::INDEX_W)
  ) u_pick (
    .vec    (candidates),
    .onehot (pick_onehot),
    .index  (pick_index),
    .any    (pick_any)
  );

  // only load into an empty register
  assign load = pick_any && (pending_r == irq_pend_pkg::PENDING_RESET);

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  logic        do_write;       // Both halves present, response free
  logic [31:0] wmask;          // Byte strobes expanded
  logic [31:0] wbits;          // Data bits under strobes
  logic [31:0] w_word;         // Word-aligned write address
  logic        wr_pending;
  logic        wr_index;
  logic        wr_sub;
  logic        wr_status;
  logic        wr_clear;
  logic        wr_enable;
  logic        wr_mapped;

  assign do_write   = aw_held_r && w_held_r && !bvalid_r;
  assign wmask      = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                       {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wbits      = w_data_r & wmask;
  assign w_word     = aw_addr_r & irq_pend_pkg::ADDR_WORD_MASK;
  assign wr_pending = do_write && (w_word == irq_pend_pkg::ADDR_IRQ_PENDING);
  assign wr_index   = do_write && (w_word == irq_pend_pkg::ADDR_IRQ_INDEX);
  assign wr_sub     = do_write && (w_word == irq_pend_pkg::ADDR_SUB_PENDING);
  assign wr_status  = do_write && (w_word == irq_pend_pkg::ADDR_EVT_STATUS);
  assign wr_clear   = do_write && (w_word == irq_pend_pkg::ADDR_EVT_CLEAR);
  assign wr_enable  = do_write && (w_word == irq_pend_pkg::ADDR_EVT_ENABLE);
  // Writes to read-only words are accepted and ignored
  assign wr_mapped  = wr_pending || wr_index || wr_sub
                    || wr_status || wr_clear || wr_enable;

  // ------------------------------------------------------------------
  // Next state of the interrupt registers
  // ------------------------------------------------------------------
  always_comb begin
    pending_nxt = pending_r;
    if (wr_pending) begin
      pending_nxt = pending_nxt & ~wbits;
    end
    if (load) begin
      pending_nxt = pending_nxt | pick_onehot;
    end
    pending_nxt = pending_nxt & irq_pend_pkg::SOURCE_VALID;
  end

  always_comb begin
    index_nxt = index_r;
    // clear once both pending bits gone
    if ((pending_r == irq_pend_pkg::PENDING_RESET)
        && !src_ctx.source_pending[index_r]) begin
      index_nxt = irq_pend_pkg::INDEX_RESET;
    end
    if (load) begin
      index_nxt = pick_index;
    end
  end

  always_comb begin
    sub_nxt = sub_r;
    if (wr_sub) begin
      sub_nxt = sub_nxt & ~wbits[irq_pend_pkg::SUB_W-1:0];
    end
    // new sub requests win over clear
    sub_nxt = sub_nxt | sub_request;
  end

  always_comb begin
    evt_status_nxt = evt_status_r;
    if (wr_clear) begin
      evt_status_nxt = evt_status_nxt & ~wbits[irq_pend_pkg::EVT_W-1:0];
    end
    // Events arriving with a clear are kept
    evt_status_nxt[irq_pend_pkg::EVT_IRQ_TAKEN] =
      evt_status_nxt[irq_pend_pkg::EVT_IRQ_TAKEN] | load;
    evt_status_nxt[irq_pend_pkg::EVT_SUB_SET] =
      evt_status_nxt[irq_pend_pkg::EVT_SUB_SET] | (|sub_request);
  end

  assign evt_enable_nxt = wr_enable ? wbits[irq_pend_pkg::EVT_W-1:0]
                                    : evt_enable_r;

  // ------------------------------------------------------------------
  // Interrupt registers
  // ------------------------------------------------------------------
  // Pending flags and index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_r <= irq_pend_pkg::PENDING_RESET;
      index_r   <= irq_pend_pkg::INDEX_RESET;
    end else begin
      pending_r <= pending_nxt;
      index_r   <= index_nxt;
    end
  end

  // Sub-source flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_r <= irq_pend_pkg::SUB_RESET;
    end else begin
      sub_r <= sub_nxt;
    end
  end

  // Event status and enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_r <= irq_pend_pkg::EVT_RESET;
      evt_enable_r <= irq_pend_pkg::EVT_RESET;
    end else begin
      evt_status_r <= evt_status_nxt;
      evt_enable_r <= evt_enable_nxt;
    end
  end

  // Output levels track the registers they summarise, same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq_r <= 1'b0;
      evt_irq_r <= 1'b0;
    end else begin
      cpu_irq_r <= |pending_nxt;
      evt_irq_r <= |(evt_status_nxt & evt_enable_nxt);
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write channels
  // ------------------------------------------------------------------
  // Address and data captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      if (awvalid && awready_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready_r <= 1'b0;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
        awready_r <= 1'b1;
      end else begin
        awready_r <= !aw_held_r;
      end
      if (wvalid && wready_r) begin
        w_held_r  <= 1'b1;
        w_data_r  <= wdata;
        w_strb_r  <= wstrb;
        wready_r  <= 1'b0;
      end else if (do_write) begin
        w_held_r  <= 1'b0;
        wready_r  <= 1'b1;
      end else begin
        wready_r  <= !w_held_r;
      end
    end
  end

  // Write response; unmapped words answer a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= irq_pend_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? irq_pend_pkg::RESP_OKAY
                            : irq_pend_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channels
  // ------------------------------------------------------------------
  logic [31:0] rd_word;        // Word-aligned read address
  logic [31:0] rd_value;
  logic        rd_ok;

  assign rd_word = araddr & irq_pend_pkg::ADDR_WORD_MASK;

  // Read mux; clear register reads zero, reads have no side effect
  always_comb begin
    rd_value = '0;
    rd_ok    = 1'b1;
    case (rd_word)
      irq_pend_pkg::ADDR_IRQ_PENDING: begin
        rd_value = pending_r;
      end
      irq_pend_pkg::ADDR_IRQ_INDEX: begin
        rd_value = {27'h0000000, index_r};
      end
      irq_pend_pkg::ADDR_SUB_PENDING: begin
        // Upper bits read zero
        rd_value = {21'h000000, sub_r};
      end
      irq_pend_pkg::ADDR_EVT_STATUS: begin
        rd_value = {30'h00000000, evt_status_r};
      end
      irq_pend_pkg::ADDR_EVT_CLEAR: begin
        rd_value = '0;
      end
      irq_pend_pkg::ADDR_EVT_ENABLE: begin
        rd_value = {30'h00000000, evt_enable_r};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // One read in flight; address taken only while no data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= irq_pend_pkg::RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_value;
      rresp_r   <= rd_ok ? irq_pend_pkg::RESP_OKAY
                         : irq_pend_pkg::RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end else begin
      arready_r <= !rvalid_r;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign cpu_irq = cpu_irq_r;
  assign evt_irq = evt_irq_r;

endmodule // irq_pending_offset_logic

// *** tb/irq_pend_asserts.sv ***
// Checker for the IRQ pending stage, bound onto the top module's ports.
// Assumes one clock, aclk, and a synchronous active-low reset.
`timescale 1ns/10ps
module irq_pend_asserts (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   awvalid,
  input wire logic                   awready,
  input wire logic                   wvalid,
  input wire logic                   wready,
  input wire logic [1:0]             bresp,
  input wire logic                   bvalid,
  input wire logic                   bready,
  input wire logic                   arvalid,
  input wire logic                   arready,
  input wire logic                   rvalid,
  input wire logic                   rready,
  input wire irq_pend_pkg::src_ctx_t src_ctx,
  input wire logic                   cpu_irq,
  input wire logic                   evt_irq
);
  // ------------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------------
  logic [31:0] cand;      // IRQ-mode winner that may load
  logic        cand_any;  // Some winner present
  assign cand = src_ctx.grant & src_ctx.source_pending & ~src_ctx.mask &
                ~src_ctx.fiq_mode & irq_pend_pkg::SOURCE_VALID;
  assign cand_any = |cand;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Idle pending with an eligible winner
  sequence cand_seen;
    !cpu_irq && cand_any;
  endsequence
  // Address and data taken on one edge
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  AST_IRQ_LOAD: assert property (cand_seen |=> cpu_irq)
    else $error("eligible request did not reach the core");
  AST_NO_STRAY: assert property ($rose(cpu_irq) |-> $past(cand_any))
    else $error("irq raised without an eligible request");
  AST_HOLD_PEND: assert property ($fell(cpu_irq) && $past(aresetn) |-> $rose(bvalid))
    else $error("pending bit dropped without a write");
  AST_WR_RESP: assert property (wr_take |-> ##2 bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response withdrawn");
  AST_R_NEXT: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data late");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid)
    else $error("read data withdrawn");
  AST_RST_QUIET: assert property ($rose(aresetn) |-> !cpu_irq && !evt_irq && !bvalid)
    else $error("outputs active out of reset");
endmodule // irq_pend_asserts

bind irq_pending_offset_logic irq_pend_asserts u_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rvalid, .rready, .src_ctx, .cpu_irq, .evt_irq
);

// *** tb/irq_core_model.sv ***
// Model of the core side: latched source requests and taken IRQs.
// Assumes set and clear pulses come from the bench on aclk.
`timescale 1ns/10ps
module irq_core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cpu_irq,
  input  wire logic [31:0] set_src,
  input  wire logic [31:0] clr_src,
  output logic      [31:0] src_pend,
  output logic      [7:0]  irq_seen
);
  logic irq_d;  // Last cycle's irq, for edge count

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_pend <= 32'h0000_0000;
    end else begin
      src_pend <= (src_pend | set_src) & ~clr_src;
    end
  end

  // Count IRQs taken; a slow core only sees rising edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_d    <= 1'b0;
      irq_seen <= 8'h00;
    end else begin
      irq_d <= cpu_irq;
      if (cpu_irq && !irq_d) begin
        irq_seen <= irq_seen + 8'h01;
      end
    end
  end
endmodule // irq_core_model

// *** tb/irq_pending_offset_logic_test.sv ***
// Self-checking bench for the IRQ pending stage over AXI4-Lite.
// Assumes the checker binds itself; the core model latches sources.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module irq_pending_offset_logic_test;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic                   aclk = 1'b0;
  logic                   aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid, cpu_irq, evt_irq;
  logic [31:0]            awaddr, wdata, araddr, rdata, set_src, clr_src;
  logic [31:0]            src_pend, mask_r, fiq_r, grant_r, e, k;
  logic [2:0]             awprot, arprot;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp, r;
  logic [10:0]            s, acc;
  logic [7:0]             irq_seen;
  logic                   m, f;
  irq_pend_pkg::src_ctx_t src_ctx;
  irq_pend_pkg::sub_req_t sub_request;
  int                     miscompares, checks_done, n_irq, i, b;

  assign src_ctx = {src_pend, mask_r, fiq_r, grant_r};
  always #20 aclk = ~aclk;

  irq_pending_offset_logic u_dut (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .src_ctx, .sub_request,
    .cpu_irq, .evt_irq
  );
  irq_core_model u_core (
    .aclk, .aresetn, .cpu_irq, .set_src, .clr_src, .src_pend, .irq_seen
  );

  // ------------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------------
  task complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write, both channels offered together
  task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      // Ready raised once the address is taken, never in the step
      // in which the previous call lowered it
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        bready <= 1'b1;
      end
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 100) begin miscompares++; complete_run; end
    bready <= 1'b0;
    rs = bresp;
  endtask
  task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      // Same for reads: a back-to-back read would toggle it in one step
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
      if (rvalid && rready) break;
    end
    if (n == 100) begin miscompares++; complete_run; end
    rready <= 1'b0;
    d = rdata;
    rs = rresp;
  endtask
  task rd_chk(input logic [31:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(a, d, rs);
    `CHK(rs, irq_pend_pkg::RESP_OKAY)
    `CHK(d, x)
  endtask
  // One-cycle set and clear of latched sources
  task pulse(input logic [31:0] sv, input logic [31:0] cv);
    set_src <= sv;
    clr_src <= cv;
    tick(1);
    set_src <= 32'h0;
    clr_src <= 32'h0;
  endtask
  task service;
    logic [31:0] d;
    grant_r <= 32'h0;
    pulse(32'h0, 32'hffff_ffff);
    rd(irq_pend_pkg::ADDR_IRQ_PENDING, d, r);
    wr(irq_pend_pkg::ADDR_IRQ_PENDING, d, r);
  endtask
  // Only unmasked IRQ-mode, non-reserved sources load
  function automatic logic [31:0] exp_pend(int bit_n, logic mk, logic fq);
    exp_pend = (bit_n == 24 || bit_n == 6 || mk || fq) ? 32'h0 : 32'h1 << bit_n;
  endfunction

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wdata, araddr, set_src, clr_src, mask_r, fiq_r, grant_r} = '0;
    {awprot, arprot, sub_request} = '0;
    wstrb = 4'hf;
    void'($urandom(62248));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    rd_chk(irq_pend_pkg::ADDR_IRQ_PENDING, 32'h0);
    rd_chk(irq_pend_pkg::ADDR_IRQ_INDEX, 32'h0);
    rd_chk(irq_pend_pkg::ADDR_SUB_PENDING, 32'h0);
    rd(32'h4a00_0030, e, r);
    `CHK(r, irq_pend_pkg::RESP_SLVERR)
    $display("reset test done");
    for (i = 0; i < 12; i++) begin
      b = (i == 0) ? 24 : (i == 1) ? 6 : $urandom_range(31, 0);
      m = ($urandom_range(3, 0) == 0);
      f = ($urandom_range(3, 0) == 0);
      e = exp_pend(b, m, f);
      mask_r <= {31'h0, m} << b;
      fiq_r <= {31'h0, f} << b;
      grant_r <= 32'h1 << b;
      pulse(32'h1 << b, 32'h0);
      tick(2);
      `CHK(cpu_irq, e != 32'h0)
      rd_chk(irq_pend_pkg::ADDR_IRQ_PENDING, e);
      rd_chk(irq_pend_pkg::ADDR_IRQ_INDEX, (e != 32'h0) ? 32'(b) : 32'h0);
      if (e != 32'h0) n_irq++;
      service;
      tick(2);
      rd_chk(irq_pend_pkg::ADDR_IRQ_PENDING, 32'h0);
      rd_chk(irq_pend_pkg::ADDR_IRQ_INDEX, 32'h0);
    end
    `CHK(irq_seen, 8'(n_irq))
    $display("random arbitration test done");
    mask_r <= 32'h0;
    fiq_r <= 32'h0;
    grant_r <= 32'h200;
    pulse(32'h208, 32'h0);
    tick(2);
    rd_chk(irq_pend_pkg::ADDR_IRQ_PENDING, 32'h200);
    grant_r <= 32'h8;
    tick(2);
    rd_chk(irq_pend_pkg::ADDR_IRQ_PENDING, 32'h200);
    fiq_r <= 32'h8;
    wr(irq_pend_pkg::ADDR_IRQ_PENDING, 32'h200, r);
    tick(2);
    rd_chk(irq_pend_pkg::ADDR_IRQ_PENDING, 32'h0);
    rd_chk(irq_pend_pkg::ADDR_IRQ_INDEX, 32'h9);
    wr(irq_pend_pkg::ADDR_IRQ_INDEX, 32'h1f, r);
    rd_chk(irq_pend_pkg::ADDR_IRQ_INDEX, 32'h9);
    pulse(32'h0, 32'h200);
    tick(2);
    rd_chk(irq_pend_pkg::ADDR_IRQ_INDEX, 32'h0);
    service;
    $display("held pending test done");
    acc = 11'h0;
    for (i = 0; i < 6; i++) begin
      s = (i == 0) ? 11'h7ff : 11'($urandom_range(2047, 0));
      sub_request <= s;
      tick(1);
      sub_request <= '0;
      acc = acc | s;
      tick(1);
      rd_chk(irq_pend_pkg::ADDR_SUB_PENDING, {21'h0, acc});
      k = $urandom;
      wr(irq_pend_pkg::ADDR_SUB_PENDING, k, r);
      acc = acc & ~k[10:0];
      rd_chk(irq_pend_pkg::ADDR_SUB_PENDING, {21'h0, acc});
    end
    $display("sub pending test done");
    wr(irq_pend_pkg::ADDR_EVT_ENABLE, 32'h3, r);
    tick(2);
    rd_chk(irq_pend_pkg::ADDR_EVT_STATUS, 32'h3);
    `CHK(evt_irq, 1'b1)
    wr(irq_pend_pkg::ADDR_EVT_ENABLE, 32'h0, r);
    tick(2);
    `CHK(evt_irq, 1'b0)
    wr(irq_pend_pkg::ADDR_EVT_ENABLE, 32'h3, r);
    wr(irq_pend_pkg::ADDR_EVT_CLEAR, 32'h3, r);
    tick(2);
    rd_chk(irq_pend_pkg::ADDR_EVT_STATUS, 32'h0);
    `CHK(evt_irq, 1'b0)
    wr(32'h4a00_0040, 32'h1, r);
    `CHK(r, irq_pend_pkg::RESP_SLVERR)
    $display("event test done");
    complete_run;
  end
endmodule // irq_pending_offset_logic_test
